// >>> dsi_error_status_flags_test.sv
// Purpose: Self-checking bench of the sticky error flags and interrupt pin
// Assumes: Registers reached through the parallel strobe port
// Notes:   Expected values come from a bench model of the register map
`timescale 1ns/1ps
`include "dsief_regs.svh"
module dsi_error_status_flags_test
  import dsief_pkg::*;
;
  logic ref_clk;
  logic rstn;
  logic pllLocked;
  logic linkClk;
  dsief_evt_t aEvt;
  dsief_evt_t bEvt;
  dsief_reg_req_t regReq;
  logic [7:0] rdData;
  logic irqOut;
  logic irqOe;
  wire logic pinLevel = irqOe ? irqOut : 1'bz; // Pin floats when not driven
  logic [7:0] ctl, enA, enB, staA, staB; // Bench model of the registers
  int nMismatch;
  int checkCount;
  int i;

  dsief_status i_dut (.ref_clk(ref_clk), .rstn(rstn), .linkClk(linkClk), .aFaultEvt(aEvt),
    .bFaultEvt(bEvt), .pllLocked(pllLocked), .regReq(regReq), .rdData(rdData),
    .irqOut(irqOut), .irqOe(irqOe));
  dsief_fault_source i_src (.linkClk(linkClk), .aEvt(aEvt), .bEvt(bEvt));

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock, 25 ns
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Compare a register read
  task automatic chkReg(input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH rdData expected %h seen %h", exp, got);
    end
  endtask

  // Compare the resolved interrupt pin
  task automatic chkPin(input logic exp, input logic got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH irqPin expected %b seen %b", exp, got);
    end
  endtask

  // Model read value, reserved bits and unmapped places read zero
  function automatic logic [7:0] model(input logic [7:0] a);
    case (a)
      `DSIEF_IRQ_CTRL_OFS: return ctl & `DSIEF_IRQ_CTRL_MASK;
      `DSIEF_ENA_A_OFS: return enA & `DSIEF_CH_A_MASK;
      `DSIEF_ENA_B_OFS: return enB & `DSIEF_CH_B_MASK;
      `DSIEF_STA_A_OFS: return staA;
      `DSIEF_STA_B_OFS: return staB;
      default: return 8'h00;
    endcase
  endfunction

  // Model pin: Z unless enabled, else high on any enabled pending flag
  function automatic logic pinExp();
    if (!ctl[0]) return 1'bz;
    return |((staA & enA & `DSIEF_CH_A_MASK) | (staB & enB & `DSIEF_CH_B_MASK));
  endfunction

  // One write strobe, then model update
  task automatic regWr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge ref_clk);
    regReq.wr = 1'b0;
    case (a)
      `DSIEF_IRQ_CTRL_OFS: ctl = v;
      `DSIEF_ENA_A_OFS: enA = v;
      `DSIEF_ENA_B_OFS: enB = v;
      `DSIEF_STA_A_OFS: staA = staA & ~(v & `DSIEF_CH_A_MASK);
      `DSIEF_STA_B_OFS: staB = staB & ~(v & `DSIEF_CH_B_MASK);
      default: ;
    endcase
  endtask

  // One read strobe, answer compared after the taking edge
  task automatic regRd(input logic [7:0] a);
    logic [7:0] exp;
    exp = model(a);
    @(negedge ref_clk);
    regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    regReq.rd = 1'b0;
    chkReg(exp, rdData);
  endtask

  // Strobe frame through the partner, then let the crossing settle
  task automatic fire(input dsief_evt_t a, input dsief_evt_t b);
    i_src.send(a, b);
    repeat (5) @(negedge ref_clk);
    staA = staA | {a, 2'b00};
    staB = staB | {b, 2'b00};
  endtask

  task automatic endOfTest();
    if (nMismatch == 0 && checkCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog cuts a hang short
  initial begin
    #100us;
    nMismatch++;
    endOfTest();
  end

  // Main sequence
  initial begin
    void'($urandom(8877));
    nMismatch = 0;
    checkCount = 0;
    rstn = 1'b0;
    pllLocked = 1'b1;
    regReq = '0;
    {ctl, enA, enB, staB} = '0;
    staA = `DSIEF_STA_A_RST;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    for (i = 'he0; i <= 'he7; i++) regRd(8'(i));
    chkPin(pinExp(), pinLevel);
    regWr(8'he5, 8'h00);
    regRd(8'he5);
    regWr(8'he5, 8'h01);
    regWr(8'he3, 8'hff);
    regRd(8'he5);
    regRd(8'he3);
    // Walking then random faults, random masks and clears
    for (i = 0; i < 12; i++) begin
      if (i < 6) fire(6'(1 << i), 6'(1 << (5 - i)));
      else fire(6'($urandom), 6'($urandom));
      regRd(8'he5);
      regRd(8'he6);
      regWr(8'he0, 8'($urandom));
      regWr(8'he1, 8'($urandom));
      regWr(8'he2, 8'($urandom));
      for (int k = 'he0; k <= 'he2; k++) regRd(8'(k));
      repeat (2) @(negedge ref_clk);
      chkPin(pinExp(), pinLevel);
      regWr(8'he5, 8'($urandom));
      regWr(8'he6, 8'($urandom));
      regRd(8'he5);
      regRd(8'he6);
    end
    // Lock loss sets the flag, lock regain does not
    @(negedge ref_clk) pllLocked = 1'b0;
    repeat (6) @(negedge ref_clk);
    staA = staA | 8'h01;
    regRd(8'he5);
    regWr(8'he5, 8'h01);
    @(negedge ref_clk) pllLocked = 1'b1;
    repeat (6) @(negedge ref_clk);
    regRd(8'he5);
    // Clear and set of one flag on the same edge: the set is kept
    regWr(8'he5, 8'hfd);
    fork
      i_src.send(6'h10, 6'h00);
      begin
        // Write lands on the edge that takes the crossed strobe
        repeat (3) @(negedge ref_clk);
        regWr(8'he5, 8'h40);
      end
    join
    repeat (5) @(negedge ref_clk);
    staA = staA | 8'h40;
    regRd(8'he5);
    // Pin high, then driven low, then floating
    regWr(8'he0, 8'h01);
    regWr(8'he2, 8'hff);
    fire(6'h00, 6'h20);
    chkPin(pinExp(), pinLevel);
    regWr(8'he6, 8'hff);
    repeat (2) @(negedge ref_clk);
    chkPin(pinExp(), pinLevel);
    regWr(8'he0, 8'h00);
    repeat (2) @(negedge ref_clk);
    chkPin(pinExp(), pinLevel);
    // Reset in mid-run brings back every reset value
    @(negedge ref_clk) rstn = 1'b0;
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    {ctl, enA, enB, staB} = '0;
    staA = `DSIEF_STA_A_RST;
    repeat (3) @(negedge ref_clk);
    for (i = 'he0; i <= 'he6; i++) regRd(8'(i));
    chkPin(pinExp(), pinLevel);
    endOfTest();
  end
endmodule // dsi_error_status_flags_test

// >>> dsief_evt_cross.sv
// Purpose: Carries one-cycle event strobes from the link clock to the core clock
// Assumes: Strobes of one bit are spaced by at least three core cycles
// Notes:   Toggle crossing, so a stopped link clock loses nothing already sent
`timescale 1ns/1ps
module dsief_evt_cross #(
  parameter int W = 12
) (
  input wire logic linkClk,
  input wire logic linkRstn,
  input wire logic [W-1:0] linkEvt,
  input wire logic refClk,
  input wire logic refRstn,
  output logic [W-1:0] refEvt
);

  // Link side state: one toggle per event line
  typedef struct packed {
    logic [W-1:0] tog;
  } dsief_link_st_t;

  // Core side state: two-flop synchroniser plus one history stage
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } dsief_xref_st_t;

  dsief_link_st_t link_reg, link_next;
  dsief_xref_st_t xref_reg, xref_next;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: flip the toggle on each strobe
  always_comb begin
    link_next = link_reg;
    link_next.tog = link_reg.tog ^ linkEvt;
  end

  // Link domain registers
  always_ff @(posedge linkClk or negedge linkRstn) begin
    if (!linkRstn) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: first stage feeds only the second
  always_comb begin
    xref_next = xref_reg;
    xref_next.s1 = link_reg.tog;
    xref_next.s2 = xref_reg.s1;
    xref_next.s3 = xref_reg.s2;
  end

  // Core domain registers
  always_ff @(posedge refClk or negedge refRstn) begin
    if (!refRstn) begin
      xref_reg <= '0;
    end else begin
      xref_reg <= xref_next;
    end
  end

  // A change of the settled toggle is one event
  assign refEvt = xref_reg.s2 ^ xref_reg.s3;

endmodule // dsief_evt_cross

// >>> dsief_fault_source.sv
// Purpose: Packet processor stand-in that sends fault strobes on its own link clock
// Assumes: One strobe frame at a time; the caller spaces frames
// Notes:   Link clock runs only inside a frame and stands still between frames
`timescale 1ns/1ps
module dsief_fault_source
  import dsief_pkg::*;
(
  output logic linkClk,
  output dsief_evt_t aEvt,
  output dsief_evt_t bEvt
);
  // Idle: clock low, no strobes
  initial begin
    linkClk = 1'b0;
    aEvt = '0;
    bEvt = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One link cycle at 12 ns
  task automatic tick();
    #6 linkClk = 1'b1;
    #6 linkClk = 1'b0;
  endtask

  // Frame: lead-in edges, one strobe cycle, trailing edges
  task automatic send(input dsief_evt_t a, input dsief_evt_t b);
    #3;
    repeat (3) tick();
    aEvt = a;
    bEvt = b;
    tick();
    aEvt = '0;
    bEvt = '0;
    repeat (2) tick();
  endtask
endmodule // dsief_fault_source

// >>> dsief_pkg.sv
// Purpose: Types shared by the error flag block
// Assumes: Six fault kinds per channel, ordered as status bits 7 down to 2
// Notes:   Offsets and counts live in dsief_regs.svh
package dsief_pkg;

  // One strobe per fault kind; field order matches status bits 7..2
  typedef struct packed {
    logic syncFault;
    logic checksumFault;
    logic headerFatal;
    logic headerFixed;
    logic lowlevelFault;
    logic leaderFault;
  } dsief_evt_t;

  // Parallel side of the serial management port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsief_reg_req_t;

endpackage

// >>> dsief_regs.svh
// Purpose: Offsets, field positions, reset values and sync depth of the error flags
// Assumes: Registers are 8 bits wide on an 8-bit register address space
// Notes:   Definitions only
`ifndef DSIEF_REGS_SVH
`define DSIEF_REGS_SVH

// Register offsets
`define DSIEF_IRQ_CTRL_OFS 8'he0
`define DSIEF_ENA_A_OFS 8'he1
`define DSIEF_ENA_B_OFS 8'he2
`define DSIEF_STA_A_OFS 8'he5
`define DSIEF_STA_B_OFS 8'he6

// Field positions inside the status and enable registers
`define DSIEF_SYNC_BIT 7
`define DSIEF_CHECKSUM_BIT 6
`define DSIEF_FATAL_BIT 5
`define DSIEF_FIXED_BIT 4
`define DSIEF_LOWLEVEL_BIT 3
`define DSIEF_LEADER_BIT 2
`define DSIEF_PLL_BIT 0
`define DSIEF_IRQ_EN_BIT 0

// Implemented bits (reserved bits read as zero)
`define DSIEF_IRQ_CTRL_MASK 8'h01
`define DSIEF_CH_A_MASK 8'hfd
`define DSIEF_CH_B_MASK 8'hfc

// Reset values
`define DSIEF_STA_A_RST 8'h01
`define DSIEF_STA_B_RST 8'h00
`define DSIEF_ENA_RST 8'h00

// Number of flip-flops in each synchroniser
`define DSIEF_SYNC_STAGES 2

`endif

// >>> dsief_status.sv
// Purpose: Sticky error flags of two receive channels, PLL unlock flag, interrupt pin
// Assumes: Fault strobes arrive on linkClk; PLL lock and rstn are asynchronous
// Notes:   Registers reached through the parallel side of the management port
// Function
// - Channel A unexpected sync packet sets bit 7
// - Channel A payload checksum mismatch sets bit 6
// - Channel A unrepairable header error sets bit 5
// - Channel A repaired header error sets bit 4
// - Low level protocol fault sets bit 3
// - Leader sequence bit error sets bit 2
// - Lock loss sets PLL flag; resets to one
// - Flags stay until software writes one
// - Fault flags reset zero; reserved bits zero
// - Channel B unexpected sync packet sets bit 7
// - Channel B bits 6..2 as channel A
// - Interrupt pin floats unless globally enabled
// - Per-flag enable masks interrupt, not status
`timescale 1ns/1ps
`include "dsief_regs.svh"
module dsief_status
  import dsief_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire dsief_evt_t aFaultEvt,
  input wire dsief_evt_t bFaultEvt,
  input wire logic pllLocked,
  input wire dsief_reg_req_t regReq,
  output logic [7:0] rdData,
  output logic irqOut,
  output logic irqOe
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the core domain
  typedef struct packed {
    logic lockSync1; // First stage of lock synchroniser
    logic lockSync2; // Settled lock level
    logic lockPrev; // Lock level one cycle ago
    logic irqEn; // Global interrupt enable
    logic [7:0] enA; // Per-flag enables, channel A
    logic [7:0] enB; // Per-flag enables, channel B
    logic [7:0] staA; // Status flags, channel A
    logic [7:0] staB; // Status flags, channel B
    logic [7:0] rdData; // Read answer
    logic irqOut; // Pin level
    logic irqOe; // Pin drive enable
  } dsief_ref_st_t;

  dsief_ref_st_t st_reg, st_next;
  logic [1:0] rstPipe; // Reset release pipeline, core clock
  logic [1:0] linkRstPipe; // Reset release pipeline, link clock
  logic rstSync; // Released reset, core clock
  logic linkRstn; // Released reset, link clock
  logic [11:0] evtRef; // Crossed strobes, B in upper half
  dsief_evt_t evtA; // Channel A strobes in core domain
  dsief_evt_t evtB; // Channel B strobes in core domain
  logic pllFall; // Lock lost this cycle
  logic [7:0] setA; // Set requests, channel A
  logic [7:0] setB; // Set requests, channel B
  logic hitA; // Write to status A
  logic hitB; // Write to status B
  logic irqAny; // Some enabled flag is active

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Write decode for one offset
  function automatic logic regHit(dsief_reg_req_t req, logic [7:0] ofs);
    return req.wr && (req.addr == ofs);
  endfunction

  // Write-one-to-clear with set priority
  function automatic logic [7:0] w1c(logic [7:0] cur, logic [7:0] set, logic hit,
                                     logic [7:0] wd, logic [7:0] mask);
    logic [7:0] clr;
    clr = hit ? wd : 8'h00;
    return ((cur & ~clr) | set) & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release, one pipeline per clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  // Link clock copy of the reset
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      linkRstPipe <= 2'h0;
    end else begin
      linkRstPipe <= {linkRstPipe[0], 1'b1};
    end
  end

  assign rstSync = rstPipe[1];
  assign linkRstn = linkRstPipe[1];

  ////////////////////////////////////////////////////////////////////////////
  // Fault strobes cross from the link clock
  dsief_evt_cross #(
    .W(12)
  ) u_cross (
    .linkClk(linkClk),
    .linkRstn(linkRstn),
    .linkEvt({bFaultEvt, aFaultEvt}),
    .refClk(ref_clk),
    .refRstn(rstSync),
    .refEvt(evtRef)
  );

  assign evtA = evtRef[5:0];
  assign evtB = evtRef[11:6];

  ////////////////////////////////////////////////////////////////////////////
  // Set sources and decodes
  always_comb begin
    // Falling edge of the settled lock level
    pllFall = st_reg.lockPrev & ~st_reg.lockSync2;
    setA = 8'h00;
    setA[`DSIEF_SYNC_BIT:`DSIEF_LEADER_BIT] = evtA;
    setA[`DSIEF_PLL_BIT] = pllFall;
    setB = 8'h00;
    setB[`DSIEF_SYNC_BIT:`DSIEF_LEADER_BIT] = evtB;
    hitA = regHit(regReq, `DSIEF_STA_A_OFS);
    hitB = regHit(regReq, `DSIEF_STA_B_OFS);
    // Masked flags still stay in status
    irqAny = |((st_reg.staA & st_reg.enA) | (st_reg.staB & st_reg.enB));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next = st_reg;
    // Lock level synchroniser and history
    st_next.lockSync1 = pllLocked;
    st_next.lockSync2 = st_reg.lockSync1;
    st_next.lockPrev = st_reg.lockSync2;
    // Plain read/write control registers
    if (regHit(regReq, `DSIEF_IRQ_CTRL_OFS)) begin
      st_next.irqEn = regReq.wdata[`DSIEF_IRQ_EN_BIT];
    end
    if (regHit(regReq, `DSIEF_ENA_A_OFS)) begin
      st_next.enA = regReq.wdata & `DSIEF_CH_A_MASK;
    end
    if (regHit(regReq, `DSIEF_ENA_B_OFS)) begin
      st_next.enB = regReq.wdata & `DSIEF_CH_B_MASK;
    end
    // Sticky flags; reserved bits forced to zero
    st_next.staA = w1c(st_reg.staA, setA, hitA, regReq.wdata,
                       `DSIEF_CH_A_MASK);
    st_next.staB = w1c(st_reg.staB, setB, hitB, regReq.wdata,
                       `DSIEF_CH_B_MASK);
    // Read answer, held until the next read
    if (regReq.rd) begin
      case (regReq.addr)
        `DSIEF_IRQ_CTRL_OFS: st_next.rdData = {7'h00, st_reg.irqEn};
        `DSIEF_ENA_A_OFS: st_next.rdData = st_reg.enA;
        `DSIEF_ENA_B_OFS: st_next.rdData = st_reg.enB;
        `DSIEF_STA_A_OFS: st_next.rdData = st_reg.staA;
        `DSIEF_STA_B_OFS: st_next.rdData = st_reg.staB;
        default: st_next.rdData = 8'h00;
      endcase
    end
    // Pin: driven only while globally enabled
    st_next.irqOe = st_reg.irqEn;
    st_next.irqOut = st_reg.irqEn & irqAny;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      st_reg <= '0;
      st_reg.enA <= `DSIEF_ENA_RST;
      st_reg.enB <= `DSIEF_ENA_RST;
      st_reg.staA <= `DSIEF_STA_A_RST;
      st_reg.staB <= `DSIEF_STA_B_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign rdData = st_reg.rdData;
  assign irqOut = st_reg.irqOut;
  assign irqOe = st_reg.irqOe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstSync);

  // A strobe sets its flag at the next edge
  property flagSets(logic ev, logic fl);
    ev |=> fl;
  endproperty

  // Settled lock level falls
  sequence lockFall;
    st_reg.lockSync2 ##1 !st_reg.lockSync2;
  endsequence

  syncFlagA_a: assert property (flagSets(evtA.syncFault, st_reg.staA[7]))
    else $error("channel A sync flag not set");
  crcFlagA_a: assert property (flagSets(evtA.checksumFault, st_reg.staA[6]))
    else $error("channel A checksum flag not set");
  fatalFlagA_a: assert property (flagSets(evtA.headerFatal, st_reg.staA[5]))
    else $error("channel A fatal header flag not set");
  fixedFlagA_a: assert property (flagSets(evtA.headerFixed, st_reg.staA[4]))
    else $error("channel A fixed header flag not set");
  lowlevelFlag_a: assert property ((evtA.lowlevelFault |=> st_reg.staA[3]) and
                                   (evtB.lowlevelFault |=> st_reg.staB[3]))
    else $error("low level flag not set");
  leaderFlagA_a: assert property (flagSets(evtA.leaderFault, st_reg.staA[2]))
    else $error("channel A leader flag not set");
  pllUnlock_a: assert property (lockFall |=> st_reg.staA[0])
    else $error("unlock flag not set after lock loss");
  flagHold_a: assert property ((setA == 8'h00) && !hitA |=> $stable(st_reg.staA))
    else $error("channel A flags changed without cause");
  flagClear_a: assert property (hitA && regReq.wdata[7] && !setA[7] |=> !st_reg.staA[7])
    else $error("write one did not clear flag");
  reservedZero_a: assert property (!st_reg.staA[1] && st_reg.staB[1:0] == 2'b00)
    else $error("reserved status bit set");
  syncFlagB_a: assert property (flagSets(evtB.syncFault, st_reg.staB[7]))
    else $error("channel B sync flag not set");
  flagsB_a: assert property (evtB != 6'h00 |=>
                             (st_reg.staB[7:2] & $past(evtB)) == $past(evtB))
    else $error("channel B flag not set");
  irqFloat_a: assert property (!st_reg.irqEn |=> !irqOe && !irqOut)
    else $error("interrupt pin driven while disabled");
  irqDrive_a: assert property (st_reg.irqEn && irqAny |=> irqOe && irqOut)
    else $error("interrupt pin not driven high");
  maskHides_a: assert property (!irqAny |=> !irqOut)
    else $error("masked flag reached the pin");
  setWins_a: assert property (hitA && regReq.wdata[6] && setA[6] |=> st_reg.staA[6])
    else $error("clear beat a simultaneous set");

endmodule // dsief_status
